/* File: hw/umc_pkg.sv */
// Package with offsets, field positions, reset values and timing for the control register bank.
package umc_pkg;

  // Register indices; the APB byte address is four times the index.
  localparam logic [15:0] IDX_INSERT_COUNT = 16'h8400;
  localparam logic [15:0] IDX_NV_ACCESS    = 16'ha004;
  localparam logic [15:0] IDX_GEN_CONTROL  = 16'ha010;
  localparam logic [15:0] IDX_LANE_TRANSMIT_DISABLE_PIN  = 16'ha013;
  localparam logic [15:0] IDX_IRQ_STATUS   = 16'ha0f0;
  localparam logic [15:0] IDX_IRQ_MASK     = 16'ha0f1;

  localparam int ADDR_W = 18;
  localparam int DATA_W = 32;
  localparam int REG_W  = 16;

  // General control field positions.
  localparam int GC_SOFT_RESET  = 15;
  localparam int GC_SOFT_LOPWR  = 14;
  localparam int GC_SOFT_TXDIS  = 13;
  localparam int GC_SOFT_PRG3   = 12;
  localparam int GC_SOFT_PRG2   = 11;
  localparam int GC_SOFT_PRG1   = 10;
  localparam int GC_ALARM_TEST  = 9;
  localparam int GC_PIN_TXDIS   = 5;
  localparam int GC_PIN_LOPWR   = 4;
  localparam int GC_PIN_PRG3    = 3;
  localparam int GC_PIN_PRG2    = 2;
  localparam int GC_PIN_PRG1    = 1;

  // Writable bits of general control; bits 8 to 6 and 0 are reserved.
  localparam logic [15:0] GC_RW_MASK = 16'hfe00;

  // Command value that saves the nonvolatile register set.
  localparam logic [15:0] NV_SAVE_CMD = 16'h0020;

  // Interrupt status and mask fields.
  localparam int IRQ_SAVE_DONE   = 0;
  localparam int IRQ_CLEAR_DONE  = 1;
  localparam int IRQ_INSERTED    = 2;
  localparam int IRQ_N           = 3;
  localparam int ST_SAVE_BUSY    = 8;
  localparam int ST_CLEAR_BUSY   = 9;

  // Reset values.
  localparam logic [15:0] RST_GEN_CONTROL = 16'h0000;
  localparam logic [15:0] RST_LANE_TRANSMIT_DISABLE_PIN = 16'h0000;
  localparam logic [15:0] RST_NV_ACCESS   = 16'h0000;
  localparam logic [15:0] RST_INSERT_CNT  = 16'h0000;
  localparam logic [2:0]  RST_IRQ_MASK    = 3'h0;

  // Synchronised pin slots and their idle levels.
  localparam int PIN_RESET_N = 0;
  localparam int PIN_LOPWR   = 1;
  localparam int PIN_TXDIS   = 2;
  localparam int PIN_PRG1    = 3;
  localparam int PIN_PRG2    = 4;
  localparam int PIN_PRG3    = 5;
  localparam int PIN_INSERT  = 6;
  localparam int PIN_N       = 7;
  localparam logic [6:0] PIN_IDLE = 7'h01;

  // Timing.
  localparam int CLK_MHZ          = 125;
  localparam int NV_SAVE_TIME_MS  = 2000;
  localparam int CNT_CLEAR_TIME_MS = 2000;
  localparam int NV_SAVE_CYCLES   = NV_SAVE_TIME_MS * CLK_MHZ * 1000;
  localparam int CNT_CLEAR_CYCLES = CNT_CLEAR_TIME_MS * CLK_MHZ * 1000;
  localparam int TIMER_W          = 28;
  localparam int SOFT_RESET_CYCLES = 16;
  localparam logic [4:0] SOFT_RESET_LEN = 5'h10;

endpackage

/* File: hw/umc_op_timer.sv */
// One-shot busy timer for slow nonvolatile operations.
`timescale 1ns/1ps
module umc_op_timer #(
  parameter int CYCLES = 16
) (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic start,
  output logic      busy,
  output logic      done
);

  logic [umc_pkg::TIMER_W-1:0] count_r;
  logic [umc_pkg::TIMER_W-1:0] count_nxt;
  logic                        busy_r;
  logic                        busy_nxt;
  logic                        done_r;
  logic                        last_w;

  // A start while busy restarts the wait so the latest request completes in full.
  assign last_w    = busy_r && (count_r == '0);
  assign count_nxt = start  ? umc_pkg::TIMER_W'(CYCLES - 1) :
                     busy_r ? count_r - umc_pkg::TIMER_W'(1) : count_r;
  assign busy_nxt  = start | (busy_r & ~last_w);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count_r <= '0;
      busy_r  <= 1'b0;
      done_r  <= 1'b0;
    end else begin
      count_r <= count_nxt;
      busy_r  <= busy_nxt;
      done_r  <= last_w & ~start;
    end
  end

  assign busy = busy_r;
  assign done = done_r;

endmodule

/* File: hw/umc_ctrl_regs.sv */
// General control register bank of the pluggable module, reached over APB.
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
// How it works
// R1: Soft reset bit self-clears, ORed with pin.
// R2: Soft low power bit ORed with pin.
// R3: Soft transmit disable ORed with pin.
// R4: Bits 12..10 soft programmable controls 3..1.
// R5: Bit 9 forces global alarm output.
// R6: Read-only bits show logical pin states.
// R7: Reserved bits read zero, ignore writes.
// R8: Lane mask bit n disables lane n.
// R9: Writing 0x0020 saves nonvolatile set, slow.
// R10: Insertion count readable, host-clearable, slow.
module umc_ctrl_regs #(
  parameter int NV_SAVE_CYCLES   = umc_pkg::NV_SAVE_CYCLES,
  parameter int CNT_CLEAR_CYCLES = umc_pkg::CNT_CLEAR_CYCLES
) (
  input  wire logic                        clk,
  input  wire logic                        reset_n,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [umc_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [umc_pkg::DATA_W-1:0]  pwdata,
  input  wire logic [3:0]                  pstrb,
  output logic      [umc_pkg::DATA_W-1:0]  prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic                        module_hard_reset_pin_n,
  input  wire logic                        low_power_request_pin,
  input  wire logic                        transmit_disable_pin,
  input  wire logic                        prog_control_input_1,
  input  wire logic                        prog_control_input_2,
  input  wire logic                        prog_control_input_3,
  input  wire logic                        insertion_detect_pin,
  output logic                             module_reset_out,
  output logic                             low_power_out,
  output logic                             transmit_disable_out,
  output logic                             prog_control_out_1,
  output logic                             prog_control_out_2,
  output logic                             prog_control_out_3,
  output logic                             global_alarm_output,
  output logic      [15:0]                 lane_tx_disable,
  output logic                             nv_save_start,
  output logic                             nv_save_busy,
  output logic                             irq
);

  // Pin synchronisers: three stages, the filtered level moves when stages two and three agree.
  logic [umc_pkg::PIN_N-1:0] pin_raw;
  logic [umc_pkg::PIN_N-1:0] sync1_r;
  logic [umc_pkg::PIN_N-1:0] sync2_r;
  logic [umc_pkg::PIN_N-1:0] sync3_r;
  logic [umc_pkg::PIN_N-1:0] pin_r;

  assign pin_raw[umc_pkg::PIN_RESET_N] = module_hard_reset_pin_n;
  assign pin_raw[umc_pkg::PIN_LOPWR]   = low_power_request_pin;
  assign pin_raw[umc_pkg::PIN_TXDIS]   = transmit_disable_pin;
  assign pin_raw[umc_pkg::PIN_PRG1]    = prog_control_input_1;
  assign pin_raw[umc_pkg::PIN_PRG2]    = prog_control_input_2;
  assign pin_raw[umc_pkg::PIN_PRG3]    = prog_control_input_3;
  assign pin_raw[umc_pkg::PIN_INSERT]  = insertion_detect_pin;

  genvar gi;
  generate
    for (gi = 0; gi < umc_pkg::PIN_N; gi++) begin : g_sync
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          sync1_r[gi] <= umc_pkg::PIN_IDLE[gi];
          sync2_r[gi] <= umc_pkg::PIN_IDLE[gi];
          sync3_r[gi] <= umc_pkg::PIN_IDLE[gi];
          pin_r[gi]   <= umc_pkg::PIN_IDLE[gi];
        end else begin
          sync1_r[gi] <= pin_raw[gi];
          sync2_r[gi] <= sync1_r[gi];
          sync3_r[gi] <= sync2_r[gi];
          if (sync2_r[gi] == sync3_r[gi]) begin
            pin_r[gi] <= sync3_r[gi];
          end
        end
      end
    end
  endgenerate

  // Logical pin states, one meaning asserted.
  wire pin_reset_asserted = ~pin_r[umc_pkg::PIN_RESET_N];
  wire pin_lopwr          = pin_r[umc_pkg::PIN_LOPWR];
  wire pin_txdis          = pin_r[umc_pkg::PIN_TXDIS];
  wire pin_prg1           = pin_r[umc_pkg::PIN_PRG1];
  wire pin_prg2           = pin_r[umc_pkg::PIN_PRG2];
  wire pin_prg3           = pin_r[umc_pkg::PIN_PRG3];
  wire pin_insert         = pin_r[umc_pkg::PIN_INSERT];

  // APB decode. Every access takes one wait state so read data can come from a register.
  logic                       ready_r;
  logic                       slverr_r;
  logic [umc_pkg::DATA_W-1:0] rdata_r;

  wire [15:0] reg_idx     = paddr[17:2];
  wire        addr_align  = (paddr[1:0] == 2'h0);
  wire        sel_count   = addr_align && (reg_idx == umc_pkg::IDX_INSERT_COUNT);
  wire        sel_nv      = addr_align && (reg_idx == umc_pkg::IDX_NV_ACCESS);
  wire        sel_gc      = addr_align && (reg_idx == umc_pkg::IDX_GEN_CONTROL);
  wire        sel_lane    = addr_align && (reg_idx == umc_pkg::IDX_LANE_TRANSMIT_DISABLE_PIN);
  wire        sel_status  = addr_align && (reg_idx == umc_pkg::IDX_IRQ_STATUS);
  wire        sel_mask    = addr_align && (reg_idx == umc_pkg::IDX_IRQ_MASK);
  wire        sel_any     = sel_count | sel_nv | sel_gc | sel_lane | sel_status | sel_mask;
  wire        access      = psel && penable && !ready_r;
  wire        commit      = psel && penable && ready_r;
  wire        wr_commit   = commit && pwrite && sel_any;

  // Byte lanes merge into the low half-word; the upper lanes carry nothing.
  wire [15:0] wmask       = {{8{pstrb[1]}}, {8{pstrb[0]}}};
  wire [15:0] wdata       = pwdata[15:0];

  wire wr_count  = wr_commit && sel_count;
  wire wr_nv     = wr_commit && sel_nv;
  wire wr_gc     = wr_commit && sel_gc;
  wire wr_lane   = wr_commit && sel_lane;
  wire wr_status = wr_commit && sel_status;
  wire wr_mask   = wr_commit && sel_mask;

  // Control registers.
  logic [15:0] gc_r;
  logic [15:0] gc_nxt;
  logic [4:0]  soft_rst_cnt_r;
  logic [4:0]  soft_rst_cnt_nxt;
  logic [15:0] lane_r;
  logic [15:0] lane_nxt;
  logic [15:0] nv_r;
  logic [15:0] nv_nxt;
  logic [15:0] count_r;
  logic [15:0] count_nxt;
  logic        insert_d_r;

  wire [15:0] gc_merged  = (gc_r & ~wmask) | (wdata & wmask);
  wire        soft_rst_wr = wr_gc && pstrb[1] && wdata[umc_pkg::GC_SOFT_RESET];
  wire        soft_rst_end = gc_r[umc_pkg::GC_SOFT_RESET] && (soft_rst_cnt_r == 5'h01);

  // Only the writable soft bits are stored, so reserved and pin bits never hold a value.
  always_comb begin
    gc_nxt = gc_r;
    if (wr_gc) begin
      gc_nxt = gc_merged & umc_pkg::GC_RW_MASK;  // see R7
      // Writing zero to the soft reset bit leaves a running reset pulse alone.
      gc_nxt[umc_pkg::GC_SOFT_RESET] = gc_r[umc_pkg::GC_SOFT_RESET] | soft_rst_wr;  // see R1
    end
    if (soft_rst_end && !soft_rst_wr) begin
      gc_nxt[umc_pkg::GC_SOFT_RESET] = 1'b0;  // see R1
    end
  end

  // The soft reset is held a fixed number of cycles so downstream logic sees a real pulse.
  always_comb begin
    soft_rst_cnt_nxt = soft_rst_cnt_r;
    if (soft_rst_wr) begin
      soft_rst_cnt_nxt = umc_pkg::SOFT_RESET_LEN;  // see R1
    end else if (soft_rst_cnt_r != 5'h00) begin
      soft_rst_cnt_nxt = soft_rst_cnt_r - 5'h01;
    end
  end

  assign lane_nxt = wr_lane ? ((lane_r & ~wmask) | (wdata & wmask)) : lane_r;  // see R8
  assign nv_nxt   = wr_nv ? ((nv_r & ~wmask) | (wdata & wmask)) : nv_r;

  // Save command decodes from the merged value actually stored.
  wire nv_save_cmd = wr_nv && (((nv_r & ~wmask) | (wdata & wmask)) == umc_pkg::NV_SAVE_CMD);

  // Insertion count: any write asks for a clear; the count stays zero until the clear completes.
  logic cnt_clear_busy;
  logic cnt_clear_done;
  logic save_busy;
  logic save_done;

  wire insert_edge = pin_insert && !insert_d_r;

  always_comb begin
    count_nxt = count_r;
    if (wr_count || cnt_clear_busy) begin
      count_nxt = umc_pkg::RST_INSERT_CNT;  // see R10
    end else if (insert_edge && (count_r != 16'hffff)) begin
      count_nxt = count_r + 16'h0001;  // see R10
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      gc_r           <= umc_pkg::RST_GEN_CONTROL;
      soft_rst_cnt_r <= 5'h00;
      lane_r         <= umc_pkg::RST_LANE_TRANSMIT_DISABLE_PIN;
      nv_r           <= umc_pkg::RST_NV_ACCESS;
      count_r        <= umc_pkg::RST_INSERT_CNT;
      insert_d_r     <= 1'b0;
    end else begin
      gc_r           <= gc_nxt;
      soft_rst_cnt_r <= soft_rst_cnt_nxt;
      lane_r         <= lane_nxt;
      nv_r           <= nv_nxt;
      count_r        <= count_nxt;
      insert_d_r     <= pin_insert;
    end
  end

  // Slow nonvolatile operations; the flash engine itself lies outside this block.
  umc_op_timer #(
    .CYCLES (NV_SAVE_CYCLES)
  ) u_save_timer (
    .clk     (clk),
    .reset_n (reset_n),
    .start   (nv_save_cmd),
    .busy    (save_busy),
    .done    (save_done)
  );

  umc_op_timer #(
    .CYCLES (CNT_CLEAR_CYCLES)
  ) u_clear_timer (
    .clk     (clk),
    .reset_n (reset_n),
    .start   (wr_count),
    .busy    (cnt_clear_busy),
    .done    (cnt_clear_done)
  );

  // Interrupts: sticky status, write one to clear, a new event wins over its clear.
  logic [umc_pkg::IRQ_N-1:0] status_r;
  logic [umc_pkg::IRQ_N-1:0] mask_r;
  logic                      save_start_r;
  logic                      irq_r;

  wire [umc_pkg::IRQ_N-1:0] events;
  assign events[umc_pkg::IRQ_SAVE_DONE]  = save_done;
  assign events[umc_pkg::IRQ_CLEAR_DONE] = cnt_clear_done;
  assign events[umc_pkg::IRQ_INSERTED]   = insert_edge;

  wire [umc_pkg::IRQ_N-1:0] w1c        = wr_status && pstrb[0] ? wdata[umc_pkg::IRQ_N-1:0] : '0;
  wire [umc_pkg::IRQ_N-1:0] status_nxt = (status_r & ~w1c) | events;
  wire [umc_pkg::IRQ_N-1:0] mask_nxt   = wr_mask && pstrb[0] ? wdata[umc_pkg::IRQ_N-1:0] : mask_r;
  // The interrupt is registered: one cycle of latency buys a glitch-free level at the pin.
  wire                      irq_nxt    = |(status_r & mask_r);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      status_r     <= '0;
      mask_r       <= umc_pkg::RST_IRQ_MASK;
      save_start_r <= 1'b0;
      irq_r        <= 1'b0;
    end else begin
      status_r     <= status_nxt;
      mask_r       <= mask_nxt;
      save_start_r <= nv_save_cmd;  // see R9
      irq_r        <= irq_nxt;
    end
  end

  // Read mux.
  logic [15:0] gc_read;
  always_comb begin
    gc_read = gc_r & umc_pkg::GC_RW_MASK;  // see R7
    gc_read[umc_pkg::GC_PIN_TXDIS] = pin_txdis;  // see R6
    gc_read[umc_pkg::GC_PIN_LOPWR] = pin_lopwr;  // see R6
    gc_read[umc_pkg::GC_PIN_PRG3]  = pin_prg3;  // see R6
    gc_read[umc_pkg::GC_PIN_PRG2]  = pin_prg2;  // see R6
    gc_read[umc_pkg::GC_PIN_PRG1]  = pin_prg1;  // see R6
  end

  logic [15:0] status_read;
  always_comb begin
    status_read = 16'h0000;
    status_read[umc_pkg::IRQ_N-1:0]     = status_r;
    status_read[umc_pkg::ST_SAVE_BUSY]  = save_busy;
    status_read[umc_pkg::ST_CLEAR_BUSY] = cnt_clear_busy;
  end

  wire [15:0] rd_mux = sel_count  ? count_r :
                       sel_nv     ? nv_r :
                       sel_gc     ? gc_read :
                       sel_lane   ? lane_r :
                       sel_status ? status_read :
                       sel_mask   ? {13'h0, mask_r} : 16'h0000;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ready_r  <= 1'b0;
      slverr_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
    end else begin
      ready_r  <= access;
      slverr_r <= access && !sel_any;
      if (access && !pwrite) begin
        rdata_r <= {16'h0000, rd_mux};
      end
    end
  end

  assign pready  = ready_r;
  assign pslverr = slverr_r;
  assign prdata  = rdata_r;

  // Module-facing controls. Each soft bit except the alarm test ORs with its pin so either source alone asserts.
  logic reset_out_r;
  logic lopwr_out_r;
  logic txdis_out_r;
  logic prg1_out_r;
  logic prg2_out_r;
  logic prg3_out_r;
  logic alarm_out_r;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reset_out_r <= 1'b0;
      lopwr_out_r <= 1'b0;
      txdis_out_r <= 1'b0;
      prg1_out_r  <= 1'b0;
      prg2_out_r  <= 1'b0;
      prg3_out_r  <= 1'b0;
      alarm_out_r <= 1'b0;
    end else begin
      reset_out_r <= pin_reset_asserted | gc_r[umc_pkg::GC_SOFT_RESET];  // see R1
      lopwr_out_r <= pin_lopwr | gc_r[umc_pkg::GC_SOFT_LOPWR];  // see R2
      txdis_out_r <= pin_txdis | gc_r[umc_pkg::GC_SOFT_TXDIS];  // see R3
      prg1_out_r  <= pin_prg1 | gc_r[umc_pkg::GC_SOFT_PRG1];  // see R4
      prg2_out_r  <= pin_prg2 | gc_r[umc_pkg::GC_SOFT_PRG2];  // see R4
      prg3_out_r  <= pin_prg3 | gc_r[umc_pkg::GC_SOFT_PRG3];  // see R4
      alarm_out_r <= gc_r[umc_pkg::GC_ALARM_TEST];  // see R5
    end
  end

  assign module_reset_out     = reset_out_r;
  assign low_power_out        = lopwr_out_r;
  assign transmit_disable_out = txdis_out_r;
  assign prog_control_out_1   = prg1_out_r;
  assign prog_control_out_2   = prg2_out_r;
  assign prog_control_out_3   = prg3_out_r;
  assign global_alarm_output  = alarm_out_r;
  assign lane_tx_disable      = lane_r;  // see R8
  assign nv_save_start        = save_start_r;  // see R9
  assign nv_save_busy         = save_busy;  // see R9
  assign irq                  = irq_r;

endmodule

/* File: dv/umc_host_model.sv */
// Host-side pin driver that faces the control register bank.
`timescale 1ns/1ps
module umc_host_model (
  input  wire logic       clk,
  input  wire logic [6:0] pin_req,
  output logic            module_hard_reset_pin_n,
  output logic            low_power_request_pin,
  output logic            transmit_disable_pin,
  output logic            prog_control_input_1,
  output logic            prog_control_input_2,
  output logic            prog_control_input_3,
  output logic            insertion_detect_pin
);
  // Pins move just after an edge, as a real host's registered outputs would.
  initial {insertion_detect_pin, prog_control_input_3, prog_control_input_2,
           prog_control_input_1, transmit_disable_pin, low_power_request_pin,
           module_hard_reset_pin_n} = umc_pkg::PIN_IDLE;
  always @(posedge clk) begin
    module_hard_reset_pin_n <= pin_req[umc_pkg::PIN_RESET_N];
    low_power_request_pin   <= pin_req[umc_pkg::PIN_LOPWR];
    transmit_disable_pin    <= pin_req[umc_pkg::PIN_TXDIS];
    prog_control_input_1    <= pin_req[umc_pkg::PIN_PRG1];
    prog_control_input_2    <= pin_req[umc_pkg::PIN_PRG2];
    prog_control_input_3    <= pin_req[umc_pkg::PIN_PRG3];
    insertion_detect_pin    <= pin_req[umc_pkg::PIN_INSERT];
  end
endmodule

/* File: dv/umc_ctrl_regs_properties.sv */
// Concurrent checks on the ports of the control register bank.
`timescale 1ns/1ps
module umc_ctrl_regs_properties #(
  parameter int NV_SAVE_CYCLES = 20
) (
  input wire logic        clk, reset_n, psel, penable, pwrite, pready, pslverr,
  input wire logic [17:0] paddr,
  input wire logic [31:0] pwdata, prdata,
  input wire logic [3:0]  pstrb,
  input wire logic        module_reset_out, low_power_out, transmit_disable_out,
  input wire logic        prog_control_out_1, prog_control_out_2, prog_control_out_3,
  input wire logic        global_alarm_output, nv_save_start, nv_save_busy, irq,
  input wire logic [15:0] lane_tx_disable
);
  localparam logic [17:0] A_GC   = {umc_pkg::IDX_GEN_CONTROL, 2'b00};
  localparam logic [17:0] A_LANE = {umc_pkg::IDX_LANE_TRANSMIT_DISABLE_PIN, 2'b00};
  localparam logic [17:0] A_NV   = {umc_pkg::IDX_NV_ACCESS, 2'b00};
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_wr(logic [17:0] a);
    psel && penable && pready && pwrite && paddr == a && pstrb[1:0] == 2'b11;
  endsequence
  property p_one_wait;
    $rose(penable) && psel |-> !pready ##1 pready;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("pready not after one wait state");
  property p_err_unaligned;
    psel && penable && pready && paddr[1:0] != 2'b00 |-> pslverr;
  endproperty
  a_err_unaligned: assert property (p_err_unaligned) else $error("unaligned not refused");
  property p_soft_reset;
    s_wr(A_GC) ##0 pwdata[15] |-> ##2 module_reset_out [*8];
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset not held");
  property p_soft_lopwr;
    s_wr(A_GC) ##0 pwdata[14] |-> ##2 low_power_out;
  endproperty
  a_soft_lopwr: assert property (p_soft_lopwr) else $error("low power not set");
  property p_soft_txdis;
    s_wr(A_GC) ##0 pwdata[13] |-> ##2 transmit_disable_out;
  endproperty
  a_soft_txdis: assert property (p_soft_txdis) else $error("tx disable not set");
  property p_soft_prg;
    s_wr(A_GC) ##0 pwdata[12:10] == 3'b111 |-> ##2
      prog_control_out_3 && prog_control_out_2 && prog_control_out_1;
  endproperty
  a_soft_prg: assert property (p_soft_prg) else $error("prog controls not set");
  property p_alarm;
    s_wr(A_GC) |-> ##2 global_alarm_output == $past(pwdata[9], 2);
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm does not follow bit 9");
  property p_lane;
    s_wr(A_LANE) |=> lane_tx_disable == $past(pwdata[15:0]);
  endproperty
  a_lane: assert property (p_lane) else $error("lane mask mismatch");
  property p_save;
    s_wr(A_NV) ##0 pwdata[15:0] == umc_pkg::NV_SAVE_CMD |=> nv_save_start && nv_save_busy;
  endproperty
  a_save: assert property (p_save) else $error("save not started");
  property p_busy_len;
    $rose(nv_save_busy) |-> nv_save_busy [*8];
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("save busy too short");
  property p_start_pulse;
    nv_save_start |=> !nv_save_start;
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start not a pulse");
endmodule
bind umc_ctrl_regs umc_ctrl_regs_properties #(.NV_SAVE_CYCLES(NV_SAVE_CYCLES)) props_i (
  .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pready(pready), .pslverr(pslverr), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pstrb(pstrb), .module_reset_out(module_reset_out), .low_power_out(low_power_out),
  .transmit_disable_out(transmit_disable_out), .prog_control_out_1(prog_control_out_1),
  .prog_control_out_2(prog_control_out_2), .prog_control_out_3(prog_control_out_3),
  .global_alarm_output(global_alarm_output), .nv_save_start(nv_save_start),
  .nv_save_busy(nv_save_busy), .irq(irq), .lane_tx_disable(lane_tx_disable));

/* File: dv/testbench.sv */
// Self-checking testbench for the control register bank.
`timescale 1ns/1ps
module testbench;
  logic        clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [17:0] paddr = 18'h00000;
  logic [31:0] pwdata = 32'h00000000, prdata, rd;
  logic [3:0]  pstrb = 4'hf;
  logic [6:0]  pin_req = umc_pkg::PIN_IDLE;
  logic        pready, pslverr, err, mrst_pin_n, lopwr_pin, txdis_pin, prg1_pin, prg2_pin;
  logic        prg3_pin, ins_pin, mrst_o, lopwr_o, txdis_o, prg1_o, prg2_o, prg3_o, alarm;
  logic        save_start, save_busy, irq;
  logic [15:0] lanes;
  int          miscompares = 0, checks_done = 0, cycles = 0;
  localparam logic [17:0] A_GC = {umc_pkg::IDX_GEN_CONTROL, 2'b00};
  localparam logic [17:0] A_LANE = {umc_pkg::IDX_LANE_TRANSMIT_DISABLE_PIN, 2'b00};
  localparam logic [17:0] A_NV = {umc_pkg::IDX_NV_ACCESS, 2'b00};
  localparam logic [17:0] A_CNT = {umc_pkg::IDX_INSERT_COUNT, 2'b00};
  localparam logic [17:0] A_ST = {umc_pkg::IDX_IRQ_STATUS, 2'b00};
  localparam logic [17:0] A_MSK = {umc_pkg::IDX_IRQ_MASK, 2'b00};
  always #4 clk = ~clk;
  umc_host_model umc_host_model_i (.clk(clk), .pin_req(pin_req),
    .module_hard_reset_pin_n(mrst_pin_n), .low_power_request_pin(lopwr_pin),
    .transmit_disable_pin(txdis_pin), .prog_control_input_1(prg1_pin),
    .prog_control_input_2(prg2_pin), .prog_control_input_3(prg3_pin),
    .insertion_detect_pin(ins_pin));
  umc_ctrl_regs #(.NV_SAVE_CYCLES(20), .CNT_CLEAR_CYCLES(20)) umc_ctrl_regs_i (
    .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .module_hard_reset_pin_n(mrst_pin_n),
    .low_power_request_pin(lopwr_pin), .transmit_disable_pin(txdis_pin),
    .prog_control_input_1(prg1_pin), .prog_control_input_2(prg2_pin),
    .prog_control_input_3(prg3_pin), .insertion_detect_pin(ins_pin),
    .module_reset_out(mrst_o), .low_power_out(lopwr_o), .transmit_disable_out(txdis_o),
    .prog_control_out_1(prg1_o), .prog_control_out_2(prg2_o), .prog_control_out_3(prg3_o),
    .global_alarm_output(alarm), .lane_tx_disable(lanes), .nv_save_start(save_start),
    .nv_save_busy(save_busy), .irq(irq));
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // The request is held until pready is seen high at an edge.
  task automatic apb(input logic wr, input logic [17:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input logic [17:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      summarize();
    end
  end
  initial begin
    wait_clk(2);
    reset_n <= 1'b1;
    rchk(A_GC, 32'h0);
    rchk(A_LANE, 32'h0);
    $display("test reset values done");
    apb(1'b1, A_GC, 32'h0000ffff);
    rchk(A_GC, 32'h0000fe00);
    chk({mrst_o, lopwr_o, txdis_o, prg3_o, prg2_o, prg1_o, alarm}, 32'h7f);
    wait_clk(20);
    rchk(A_GC, 32'h00007e00);
    chk(mrst_o, 32'h0);
    apb(1'b1, A_GC, 32'h00000000);
    wait_clk(2);
    chk({lopwr_o, txdis_o, prg3_o, prg2_o, prg1_o, alarm}, 32'h0);
    $display("test soft bits done");
    pin_req <= 7'h3e;
    wait_clk(8);
    rchk(A_GC, 32'h0000003e);
    chk({mrst_o, lopwr_o, txdis_o, prg3_o, prg2_o, prg1_o}, 32'h3f);
    pin_req <= umc_pkg::PIN_IDLE;
    wait_clk(8);
    chk({mrst_o, lopwr_o, txdis_o, prg3_o, prg2_o, prg1_o}, 32'h0);
    $display("test pins done");
    apb(1'b1, A_LANE, 32'h00008001);
    wait_clk(1);
    chk(lanes, 32'h8001);
    apb(1'b1, A_LANE, 32'h00005aa5);
    rchk(A_LANE, 32'h00005aa5);
    $display("test lanes done");
    apb(1'b1, A_MSK, 32'h00000007);
    apb(1'b1, A_NV, 32'h00000021);
    wait_clk(3);
    chk(save_busy, 32'h0);
    apb(1'b1, A_NV, 32'h00000020);
    wait_clk(1);
    chk(save_busy, 32'h1);
    for (int n = 0; n < 60 && save_busy === 1'b1; n++) wait_clk(1);
    wait_clk(2);
    chk(irq, 32'h1);
    rchk(A_ST, 32'h00000001);
    apb(1'b1, A_ST, 32'h00000001);
    rchk(A_ST, 32'h0);
    chk(irq, 32'h0);
    $display("test save done");
    repeat (3) begin
      pin_req <= 7'h41;
      wait_clk(5);
      pin_req <= 7'h01;
      wait_clk(5);
    end
    rchk(A_CNT, 32'h00000003);
    rchk(A_ST, 32'h00000004);
    apb(1'b1, A_ST, 32'h00000004);
    apb(1'b1, A_CNT, 32'h00000000);
    rchk(A_CNT, 32'h0);
    wait_clk(30);
    rchk(A_ST, 32'h00000002);
    $display("test counter done");
    apb(1'b0, 18'h00100, 32'h0);
    chk(err, 32'h1);
    apb(1'b1, A_GC | 18'h00001, 32'h00000200);
    chk(err, 32'h1);
    wait_clk(2);
    chk(alarm, 32'h0);
    $display("test refusals done");
    summarize();
  end
endmodule
